// >>> hw/csi_pkg.sv
package csi_pkg;

  // ****************************************
  // Clock rate and timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned FAULT_PULSE_US  = 256;
  localparam int unsigned FAULT_PULSE_CYC = (FAULT_PULSE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned DET_SETTLE_US   = 100;
  localparam int unsigned DET_SETTLE_CYC  = (DET_SETTLE_US * (CLK_HZ / 1_000_000));

  // ****************************************
  // Port classification codes
  // ****************************************
  localparam logic [2:0] PORT_NONE = 3'h0;
  localparam logic [2:0] PORT_SDP  = 3'h1;
  localparam logic [2:0] PORT_CDP  = 3'h2;
  localparam logic [2:0] PORT_DCP  = 3'h3;
  localparam logic [2:0] PORT_PROP = 3'h4;

  // ****************************************
  // Input current limit codes
  // ****************************************
  localparam logic [1:0] ILIM_100MA  = 2'h0;
  localparam logic [1:0] ILIM_500MA  = 2'h1;
  localparam logic [1:0] ILIM_1500MA = 2'h2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [2:0] PORT_RST = PORT_NONE;
  localparam logic [1:0] ILIM_RST = ILIM_100MA;

  typedef struct packed {
    logic charging;
    logic recharging;
    logic fault;
    logic stat_en;
    logic chg_en_n;
  } csi_chg_status_t;

  typedef struct packed {
    logic dp_hi;
    logic dm_hi;
    logic dp_dm_short;
    logic cdp_echo;
    logic prop_sig;
  } csi_line_sense_t;

  typedef struct packed {
    logic       pull_low;
    logic       oe;
  } csi_od_t;

endpackage

// >>> hw/csi_top.sv
`timescale 1ns/100ps
module csi_top
  import csi_pkg::*;
#(
  parameter int unsigned PULSE_CYC  = FAULT_PULSE_CYC,
  parameter int unsigned SETTLE_CYC = DET_SETTLE_CYC
) (
  input  wire logic            mclk_in,
  input  wire logic            sys_rst_in,
  input  wire csi_chg_status_t status_in,
  input  wire csi_line_sense_t lines_in,
  input  wire logic            supply_valid_in,
  output logic                 status_oe_out,
  output logic                 status_o_out,
  output logic                 charging_indicator_oe_out,
  output logic                 charging_indicator_o_out,
  output logic                 supply_good_oe_out,
  output logic                 supply_good_o_out,
  output logic [2:0]           port_type_out,
  output logic [1:0]           ilim_sel_out,
  output logic                 detect_done_out
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [4:0] ln_s1_q, ln_s2_q;
  logic       sv_s1_q, sv_s2_q, ce_s1_q, ce_s2_q;

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ln_s1_q <= 5'h00;
      ln_s2_q <= 5'h00;
      sv_s1_q <= 1'b0;
      sv_s2_q <= 1'b0;
      ce_s1_q <= 1'b1;
      ce_s2_q <= 1'b1;
    end else begin
      ln_s1_q <= lines_in;
      ln_s2_q <= ln_s1_q;
      sv_s1_q <= supply_valid_in;
      sv_s2_q <= sv_s1_q;
      ce_s1_q <= status_in.chg_en_n;
      ce_s2_q <= ce_s1_q;
    end
  end

  csi_line_sense_t ln;
  assign ln = csi_line_sense_t'(ln_s2_q);

  // ****************************************
  // Adapter detection
  // ****************************************
  typedef enum logic [1:0] {DET_SETTLE, DET_CLASSIFY, DET_DONE} csi_det_state_t;

  csi_det_state_t det_q, det_d;
  logic [31:0]    set_cnt_q, set_cnt_d;
  logic [2:0]     port_q, port_d;
  logic [1:0]     ilim_q, ilim_d;

  always_comb begin
    det_d     = det_q;
    set_cnt_d = set_cnt_q;
    port_d    = port_q;
    ilim_d    = ilim_q;
    case (det_q)
      DET_SETTLE: begin
        if (set_cnt_q >= SETTLE_CYC - 1) begin
          det_d = DET_CLASSIFY;
        end else begin
          set_cnt_d = set_cnt_q + 32'h1;
        end
      end
      DET_CLASSIFY: begin
        det_d = DET_DONE;
        if (ln.prop_sig) begin
          port_d = PORT_PROP;
          ilim_d = ILIM_500MA;
        end else if (ln.dp_dm_short) begin
          port_d = PORT_DCP;
          ilim_d = ILIM_1500MA;
        end else if (ln.cdp_echo) begin
          port_d = PORT_CDP;
          ilim_d = ILIM_1500MA;
        end else begin
          port_d = PORT_SDP;
          ilim_d = ILIM_500MA;
        end
      end
      default: begin
        det_d = DET_DONE;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      det_q     <= DET_SETTLE;
      set_cnt_q <= 32'h0;
      port_q    <= PORT_RST;
      ilim_q    <= ILIM_RST;
    end else begin
      det_q     <= det_d;
      set_cnt_q <= set_cnt_d;
      port_q    <= port_d;
      ilim_q    <= ilim_d;
    end
  end

  // ****************************************
  // Fault pulse and status outputs
  // ****************************************
  logic        fault_prev_q, fault_prev_d;
  logic [31:0] pcnt_q, pcnt_d;
  logic        pulse_q, pulse_d;
  logic        stat_pl_q, stat_pl_d;
  logic        ind_pl_q, ind_pl_d;
  logic        pg_pl_q, pg_pl_d;
  logic        enabled;

  assign enabled = ~ce_s2_q;

  always_comb begin
    fault_prev_d = status_in.fault;
    pcnt_d       = pcnt_q;
    pulse_d      = pulse_q;
    if (status_in.fault && !fault_prev_q && !pulse_q) begin
      pulse_d = 1'b1;
      pcnt_d  = 32'h0;
    end else if (pulse_q) begin
      if (pcnt_q >= PULSE_CYC - 1) begin
        pulse_d = 1'b0;
      end else begin
        pcnt_d = pcnt_q + 32'h1;
      end
    end
    stat_pl_d = enabled && (status_in.charging || status_in.recharging);
    if (pulse_d) begin
      stat_pl_d = 1'b1;
    end
    stat_pl_d = stat_pl_d && status_in.stat_en;
    ind_pl_d = enabled && status_in.charging && !status_in.recharging;
    pg_pl_d = (det_q == DET_DONE) && sv_s2_q;
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      fault_prev_q <= 1'b0;
      pcnt_q       <= 32'h0;
      pulse_q      <= 1'b0;
      stat_pl_q    <= 1'b0;
      ind_pl_q     <= 1'b0;
      pg_pl_q      <= 1'b0;
    end else begin
      fault_prev_q <= fault_prev_d;
      pcnt_q       <= pcnt_d;
      pulse_q      <= pulse_d;
      stat_pl_q    <= stat_pl_d;
      ind_pl_q     <= ind_pl_d;
      pg_pl_q      <= pg_pl_d;
    end
  end

  // Open-drain: output level always low, enable carries the pull
  assign status_oe_out             = stat_pl_q;
  assign status_o_out              = 1'b0;
  assign charging_indicator_oe_out = ind_pl_q;
  assign charging_indicator_o_out  = 1'b0;
  assign supply_good_oe_out        = pg_pl_q;
  assign supply_good_o_out         = 1'b0;
  assign port_type_out             = port_q;
  assign ilim_sel_out              = ilim_q;
  assign detect_done_out           = (det_q == DET_DONE);

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_fault_rise;
    status_in.fault && !fault_prev_q && !pulse_q;
  endsequence

  property p_pulse_len;
    @(posedge mclk_in) disable iff (sys_rst_in)
      s_fault_rise |=> pulse_q [*8];
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("fault pulse too short");

  property p_pulse_ends;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (pulse_q && pcnt_q >= PULSE_CYC - 1) |=> !pulse_q;
  endproperty
  a_pulse_ends: assert property (p_pulse_ends) else $error("fault pulse overran");

  property p_chg_low;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (status_in.charging && status_in.stat_en && enabled) |=> status_oe_out;
  endproperty
  a_chg_low: assert property (p_chg_low) else $error("status idle while charging");

  property p_rechg_low;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (status_in.recharging && status_in.stat_en && enabled) |=> status_oe_out;
  endproperty
  a_rechg_low: assert property (p_rechg_low) else $error("status idle on recharge");

  property p_stat_en;
    @(posedge mclk_in) disable iff (sys_rst_in)
      !status_in.stat_en |=> !status_oe_out;
  endproperty
  a_stat_en: assert property (p_stat_en) else $error("status driven while disabled");

  property p_release;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (!status_in.charging && !status_in.recharging && !pulse_d) |=> !status_oe_out;
  endproperty
  a_release: assert property (p_release) else $error("status not released");

  property p_ind_rechg;
    @(posedge mclk_in) disable iff (sys_rst_in)
      status_in.recharging |=> !charging_indicator_oe_out;
  endproperty
  a_ind_rechg: assert property (p_ind_rechg) else $error("indicator shows recharge");

  property p_pg_hold;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (det_q != DET_DONE) |-> !supply_good_oe_out;
  endproperty
  a_pg_hold: assert property (p_pg_hold) else $error("supply good before detection");

  property p_prop_ilim;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (det_q == DET_CLASSIFY && ln.prop_sig) |=> (ilim_sel_out == ILIM_500MA);
  endproperty
  a_prop_ilim: assert property (p_prop_ilim) else $error("proprietary limit wrong");

  property p_det_once;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (det_q == DET_CLASSIFY) |=> (det_q == DET_DONE) && (port_type_out != PORT_NONE);
  endproperty
  a_det_once: assert property (p_det_once) else $error("classification missing");

  property p_pulse_hold;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (pulse_q && (pcnt_q < PULSE_CYC - 1)) |=> pulse_q;
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("fault pulse cut short");

  property p_pulse_pin;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (pulse_d && status_in.stat_en) |=> status_oe_out;
  endproperty
  a_pulse_pin: assert property (p_pulse_pin) else $error("pulse not on pin");

  property p_standby;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (!enabled && !pulse_d) |=> !status_oe_out;
  endproperty
  a_standby: assert property (p_standby) else $error("status driven in standby");

  property p_ind_standby;
    @(posedge mclk_in) disable iff (sys_rst_in)
      !enabled |=> !charging_indicator_oe_out;
  endproperty
  a_ind_standby: assert property (p_ind_standby) else $error("indicator in standby");

  property p_ind_chg;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (status_in.charging && !status_in.recharging && enabled) |=> charging_indicator_oe_out;
  endproperty
  a_ind_chg: assert property (p_ind_chg) else $error("indicator idle while charging");

  property p_pg_follow;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (det_q == DET_DONE && sv_s2_q) |=> supply_good_oe_out;
  endproperty
  a_pg_follow: assert property (p_pg_follow) else $error("supply good not shown");

  property p_pg_nosupply;
    @(posedge mclk_in) disable iff (sys_rst_in)
      !sv_s2_q |=> !supply_good_oe_out;
  endproperty
  a_pg_nosupply: assert property (p_pg_nosupply) else $error("good without supply");

  property p_settle_first;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (det_q == DET_SETTLE) |=> (det_q != DET_DONE);
  endproperty
  a_settle_first: assert property (p_settle_first) else $error("settle skipped");

  property p_fast_ilim;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (det_q == DET_CLASSIFY && !ln.prop_sig && (ln.dp_dm_short || ln.cdp_echo))
        |=> (ilim_sel_out == ILIM_1500MA);
  endproperty
  a_fast_ilim: assert property (p_fast_ilim) else $error("fast port limit wrong");

endmodule

// >>> dv/csi_host_model.sv
`timescale 1ns/100ps
// ****************************************
// Host side: pull-ups on open-drain lines
// ****************************************
module csi_host_model (
  input  wire logic status_oe_in,
  input  wire logic ind_oe_in,
  input  wire logic good_oe_in,
  input  wire logic status_o_in,
  input  wire logic ind_o_in,
  input  wire logic good_o_in,
  output logic      status_pin_out,
  output logic      ind_pin_out,
  output logic      good_pin_out
);
  // A released line floats up through its pull-up resistor
  assign status_pin_out = status_oe_in ? status_o_in : 1'b1;
  assign ind_pin_out    = ind_oe_in ? ind_o_in : 1'b1;
  assign good_pin_out   = good_oe_in ? good_o_in : 1'b1;
endmodule

// >>> dv/tb.sv
`timescale 1ns/100ps
module tb;
  import csi_pkg::*;
  localparam int P = 16;
  localparam int S = 4;
  logic            mclk_in = 1'b0;
  logic            sys_rst_in = 1'b1;
  logic            supply_valid_in = 1'b0;
  csi_chg_status_t st = '0;
  csi_line_sense_t ln = '0;
  logic            s_oe, i_oe, g_oe, stat_pin, ind_pin, good_pin, done;
  logic            s_o, i_o, g_o;
  logic [2:0]      port;
  logic [1:0]      ilim;
  int              err_total = 0;
  int              checked = 0;
  int              cyc = 0;
  int              n;

  always #12.5 mclk_in = ~mclk_in;

  csi_top #(.PULSE_CYC(P), .SETTLE_CYC(S)) dut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .status_in(st), .lines_in(ln),
    .supply_valid_in(supply_valid_in), .status_oe_out(s_oe), .status_o_out(s_o),
    .charging_indicator_oe_out(i_oe), .charging_indicator_o_out(i_o),
    .supply_good_oe_out(g_oe), .supply_good_o_out(g_o), .port_type_out(port),
    .ilim_sel_out(ilim), .detect_done_out(done));

  csi_host_model host (
    .status_oe_in(s_oe), .ind_oe_in(i_oe), .good_oe_in(g_oe),
    .status_o_in(s_o), .ind_o_in(i_o), .good_o_in(g_o),
    .status_pin_out(stat_pin), .ind_pin_out(ind_pin), .good_pin_out(good_pin));

  // Whole run needs well under 1000 cycles
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end

  task summarize;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task tick(input int k);
    repeat (k) @(posedge mclk_in);
    #2;
  endtask

  task do_reset(input csi_line_sense_t l);
    ln = l;
    st = '0;
    supply_valid_in = 1'b1;
    sys_rst_in = 1'b1;
    tick(2);
    chk("good_pin_in_reset", 4'h1, good_pin);
    chk("done_in_reset", 4'h0, done);
    chk("port_in_reset", 4'(PORT_NONE), 4'(port));
    chk("ilim_in_reset", 4'(ILIM_100MA), 4'(ilim));
    sys_rst_in = 1'b0;
  endtask

  // Supply is valid throughout, yet the line must stay up until done
  task t_detect(input csi_line_sense_t l, input logic [2:0] ep, input logic [1:0] ei);
    do_reset(l);
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      chk("good_pin_before_done", 4'h1, good_pin);
      tick(1);
      n++;
    end
    chk("detect_done", 4'h1, done);
    tick(4);
    chk("port_type", 4'(ep), 4'(port));
    chk("ilim_sel", 4'(ei), 4'(ilim));
    chk("good_pin_after_done", 4'h0, good_pin);
  endtask

  // Supply loss after detection must release the line again
  task t_supply;
    supply_valid_in = 1'b0;
    tick(4);
    chk("good_pin_no_supply", 4'h1, good_pin);
    supply_valid_in = 1'b1;
    tick(4);
    chk("good_pin_supply_back", 4'h0, good_pin);
  endtask

  task t_status;
    st.stat_en = 1'b1;
    st.charging = 1'b1;
    tick(4);
    chk("stat_charging", 4'h0, stat_pin);
    chk("ind_charging", 4'h0, ind_pin);
    st.charging = 1'b0;
    tick(4);
    chk("stat_done", 4'h1, stat_pin);
    st.recharging = 1'b1;
    tick(4);
    chk("stat_recharge", 4'h0, stat_pin);
    chk("ind_recharge", 4'h1, ind_pin);
    st.stat_en = 1'b0;
    tick(4);
    chk("stat_disabled_bit", 4'h1, stat_pin);
    st.stat_en = 1'b1;
    st.chg_en_n = 1'b1;
    st.recharging = 1'b0;
    st.charging = 1'b1;
    tick(5);
    chk("stat_standby", 4'h1, stat_pin);
    chk("ind_standby", 4'h1, ind_pin);
    st = '0;
    tick(1);
  endtask

  task t_fault;
    st.stat_en = 1'b1;
    tick(3);
    st.fault = 1'b1;
    tick(1);
    n = 0;
    while (stat_pin === 1'b0 && n < 100) begin
      tick(1);
      n++;
    end
    chk("pulse_len_ok", 4'h1, 4'((n >= P) && (n <= P + 1)));
    tick(2 * P);
    chk("single_pulse", 4'h1, stat_pin);
    st.fault = 1'b0;
    st.charging = 1'b1;
    tick(3);
    st.fault = 1'b1;
    tick(P + 6);
    chk("stat_after_pulse", 4'h0, stat_pin);
    st = '0;
  endtask

  initial begin
    t_detect(5'h01, PORT_PROP, ILIM_500MA);
    t_detect(5'h05, PORT_PROP, ILIM_500MA);
    t_detect(5'h04, PORT_DCP, ILIM_1500MA);
    t_detect(5'h02, PORT_CDP, ILIM_1500MA);
    t_detect(5'h10, PORT_SDP, ILIM_500MA);
    t_supply();
    t_status();
    t_fault();
    summarize();
  end
endmodule
